// >>> rtl/msc_top.sv
// measurement sequence control: APB registers, selectors and trigger state machine
module msc_top (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic [31:0]      PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        TRIG_EVENT,
	output logic             MEAS_START,
	input  wire logic        MEAS_DONE,
	output logic             MEAS_ABORT,
	output logic             MEAS_ACTIVE,
	output logic [2:0]       MODE_SEL,
	output logic [2:0]       FEED_SEL,
	output logic [1:0]       EXTRA_SEL,
	output logic             USE_RANDOM,
	output logic             RESULT_READY
);
	// selector and control state
	logic [2:0] mode;
	logic [2:0] feed;
	logic [1:0] extra;
	logic       cont;
	logic       trig_en;
	logic [7:0] trig_count;
	logic [7:0] events_left;
	logic       err;
	logic       result;
	logic       start_q;
	logic       abort_q;
	logic [31:0] rdata;
	msc_pkg::msc_state_type state;

	logic [2:0] next_mode;
	logic [2:0] next_feed;
	logic [1:0] next_extra;
	logic       next_cont;
	logic       next_trig_en;
	logic [7:0] next_trig_count;
	logic [7:0] next_events_left;
	logic       next_err;
	logic       next_result;
	logic       next_start_q;
	logic       next_abort_q;
	logic [31:0] next_rdata;
	msc_pkg::msc_state_type next_state;

	logic       feed_ok;
	logic       extra_ok;
	logic [2:0] w_mode;
	logic [2:0] w_feed;
	logic [1:0] w_extra;

	// apb access phase; zero wait states
	logic acc;
	logic wr;
	logic rd;
	logic cmd_start;
	logic cmd_abort;
	logic cmd_reset;
	logic cmd_clrerr;
	logic cfg_wr;
	logic cont_off;
	logic trig_go;
	logic unmapped;

	assign acc = PSEL && PENABLE;
	assign wr  = acc && PWRITE;
	assign rd  = acc && !PWRITE;
	assign unmapped = (PADDR != msc_pkg::OFS_CONFIG) && (PADDR != msc_pkg::OFS_CMD)
	               && (PADDR != msc_pkg::OFS_STATUS) && (PADDR != msc_pkg::OFS_TRIG);
	assign cfg_wr     = wr && (PADDR == msc_pkg::OFS_CONFIG);
	assign cmd_start  = wr && (PADDR == msc_pkg::OFS_CMD) && PWDATA[msc_pkg::CMD_START_BIT];
	assign cmd_abort  = wr && (PADDR == msc_pkg::OFS_CMD) && PWDATA[msc_pkg::CMD_ABORT_BIT];
	assign cmd_reset  = wr && (PADDR == msc_pkg::OFS_CMD) && PWDATA[msc_pkg::CMD_RESET_BIT];
	assign cmd_clrerr = wr && (PADDR == msc_pkg::OFS_CMD) && PWDATA[msc_pkg::CMD_CLRERR_BIT];
	assign w_mode  = PWDATA[msc_pkg::MODE_LSB +: 3];
	assign w_feed  = PWDATA[msc_pkg::FEED_LSB +: 3];
	assign w_extra = PWDATA[msc_pkg::EXTRA_LSB +: 2];
	assign cont_off = cfg_wr && cont && !PWDATA[msc_pkg::CONT_BIT];
	// without a trigger condition any waiting state proceeds at once
	assign trig_go = !trig_en || TRIG_EVENT;

	// legality of the requested selector triple
	msc_cfg_check msc_cfg_check_i (
		.mode     (w_mode),
		.feed     (w_feed),
		.extra    (w_extra),
		.feed_ok  (feed_ok),
		.extra_ok (extra_ok)
	);

	// configuration registers, error flag and command latches
	always_comb begin
		next_mode        = mode;
		next_feed        = feed;
		next_extra       = extra;
		next_cont        = cont;
		next_trig_en     = trig_en;
		next_trig_count  = trig_count;
		next_err         = err;
		next_start_q     = cmd_start;
		next_abort_q     = cmd_abort;
		if (cmd_clrerr) begin
			next_err = 1'b0;
		end
		if (cfg_wr) begin
			next_cont    = PWDATA[msc_pkg::CONT_BIT];
			next_trig_en = PWDATA[msc_pkg::TRIGEN_BIT];
			// config writes change the selectors only in idle, whole triple at once
			if (state == msc_pkg::st_idle) begin
				if (feed_ok && extra_ok) begin
					next_mode  = w_mode;
					next_feed  = w_feed;
					next_extra = w_extra;
				end else begin
					next_err = 1'b1;
				end
			end
		end
		if (wr && (PADDR == msc_pkg::OFS_TRIG) && (state == msc_pkg::st_idle)) begin
			// a zero count is taken as one, the reset value of the count
			next_trig_count = (PWDATA[7:0] == 8'h00) ? msc_pkg::TRIG_COUNT_RST : PWDATA[7:0];
		end
		if (cmd_reset) begin
			next_mode       = 3'(msc_pkg::MODE_RST);
			next_feed       = 3'(msc_pkg::FEED_RST);
			next_extra      = 2'(msc_pkg::EXTRA_RST);
			next_cont       = 1'b0;
			next_trig_en    = 1'b0;
			next_trig_count = msc_pkg::TRIG_COUNT_RST;
		end
		if (wr && unmapped) begin
			next_err = 1'b1;
		end
	end

	// trigger state machine; start and abort act one cycle after the bus write, reset in the same cycle
	always_comb begin
		next_state       = state;
		next_events_left = events_left;
		next_result      = result;
		// clear only a flag that the read reported, so a completion after the capture is kept
		if (rd && (PADDR == msc_pkg::OFS_STATUS) && rdata[2]) begin
			next_result = 1'b0;
		end
		unique case (state)
			msc_pkg::st_idle: begin
				if (start_q || cont) begin
					next_state = msc_pkg::st_wait_trig;
					next_events_left = trig_count;
				end
			end
			msc_pkg::st_wait_trig: begin
				if (trig_go) begin
					next_state = msc_pkg::st_measuring;
				end
			end
			msc_pkg::st_measuring: begin
				if (MEAS_DONE) begin
					if (events_left > 8'h01) begin
						next_events_left = events_left - 8'h01;
						next_state = msc_pkg::st_wait_trig;
					end else if (cont) begin
						next_events_left = trig_count;
						next_state = msc_pkg::st_wait_trig;
						next_result = 1'b1;
					end else begin
						next_state = msc_pkg::st_idle;
						next_result = 1'b1;
					end
				end
			end
		endcase
		if (abort_q) begin
			next_events_left = trig_count;
			next_state = cont ? msc_pkg::st_wait_trig : msc_pkg::st_idle;
		end
		if (cont_off || cmd_reset) begin
			next_state = msc_pkg::st_idle;
		end
	end

	// read mux, reserved bits zero; captured in the setup cycle so data stands in the zero-wait access phase
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (PSEL && !PENABLE && !PWRITE) begin
			unique case (PADDR)
				msc_pkg::OFS_CONFIG: begin
					next_rdata[msc_pkg::MODE_LSB +: 3]  = mode;
					next_rdata[msc_pkg::FEED_LSB +: 3]  = feed;
					next_rdata[msc_pkg::EXTRA_LSB +: 2] = extra;
					next_rdata[msc_pkg::CONT_BIT]       = cont;
					next_rdata[msc_pkg::TRIGEN_BIT]     = trig_en;
				end
				msc_pkg::OFS_STATUS: begin
					next_rdata[1:0]  = 2'(state);
					next_rdata[2]    = result;
					next_rdata[3]    = err;
					next_rdata[15:8] = events_left;
				end
				msc_pkg::OFS_TRIG: begin
					next_rdata[7:0] = trig_count;
				end
				default: begin
					next_rdata = 32'h0000_0000;
				end
			endcase
		end else begin
			next_rdata = rdata;
		end
	end

	// all state registers; reset gives idle with default selectors
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			mode        <= 3'(msc_pkg::MODE_RST);
			feed        <= 3'(msc_pkg::FEED_RST);
			extra       <= 2'(msc_pkg::EXTRA_RST);
			cont        <= 1'b0;
			trig_en     <= 1'b0;
			trig_count  <= msc_pkg::TRIG_COUNT_RST;
			events_left <= 8'h00;
			err         <= 1'b0;
			result      <= 1'b0;
			start_q     <= 1'b0;
			abort_q     <= 1'b0;
			rdata       <= 32'h0000_0000;
			state       <= msc_pkg::st_idle;
		end else begin
			mode        <= next_mode;
			feed        <= next_feed;
			extra       <= next_extra;
			cont        <= next_cont;
			trig_en     <= next_trig_en;
			trig_count  <= next_trig_count;
			events_left <= next_events_left;
			err         <= next_err;
			result      <= next_result;
			start_q     <= next_start_q;
			abort_q     <= next_abort_q;
			rdata       <= next_rdata;
			state       <= next_state;
		end
	end

	assign PREADY       = 1'b1;
	assign PSLVERR      = acc && unmapped;
	assign PRDATA       = rdata;
	assign MEAS_START   = (state == msc_pkg::st_wait_trig) && (next_state == msc_pkg::st_measuring);
	assign MEAS_ABORT   = (state == msc_pkg::st_measuring) && abort_q;
	assign MEAS_ACTIVE  = (state == msc_pkg::st_measuring);
	assign MODE_SEL     = mode;
	assign FEED_SEL     = feed;
	assign EXTRA_SEL    = extra;
	// evaluations run on random samples instead of averages
	assign USE_RANDOM   = (extra == 2'(msc_pkg::random_sample_report));
	assign RESULT_READY = result;

	// sequencing checks on the state machine and the selector registers
	AST_ABORT_SINGLE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		abort_q && !cont |=> (state == msc_pkg::st_idle))
		else $error("abort in a single run did not end in idle");
	AST_ABORT_CONT: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		abort_q && cont && !cont_off && !cmd_reset |=> (state == msc_pkg::st_wait_trig))
		else $error("abort in a continuous run did not return to waiting");
	AST_START_WAITS: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(state == msc_pkg::st_idle) && start_q && !abort_q && !cont_off && !cmd_reset
		|=> (state == msc_pkg::st_wait_trig))
		else $error("start did not lead from idle to waiting");
	AST_FREE_RUN: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(state == msc_pkg::st_wait_trig) && !trig_en && !abort_q && !cont_off && !cmd_reset
		|-> MEAS_START)
		else $error("waiting without trigger condition did not start measuring");
	AST_SINGLE_DONE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(state == msc_pkg::st_measuring) && MEAS_DONE && (events_left <= 8'h01) && !cont
		&& !abort_q && !cmd_reset |=> (state == msc_pkg::st_idle) && result)
		else $error("completed single run did not flag a result and go idle");
	AST_CONT_DONE: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(state == msc_pkg::st_measuring) && MEAS_DONE && (events_left <= 8'h01) && cont
		&& !abort_q && !cont_off && !cmd_reset |=> (state == msc_pkg::st_wait_trig) && result)
		else $error("completed continuous run did not return to waiting");
	AST_SEL_LOCK: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		(state != msc_pkg::st_idle) && !cmd_reset |=> $stable(mode) && $stable(feed) && $stable(extra))
		else $error("selector changed outside idle");
	AST_NO_SLOT_RANDOM: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		!((mode == 3'(msc_pkg::slot_mean_mode)) && (extra == 2'(msc_pkg::random_sample_report))))
		else $error("random samples selected in timeslot mode");
endmodule // msc_top

// >>> rtl/msc_pkg.sv
// package: register map, field encodings and state types of the measurement sequence control
package msc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CONFIG = 8'h00;
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_TRIG   = 8'h0C;
	// config field positions
	localparam int MODE_LSB  = 0;
	localparam int FEED_LSB  = 4;
	localparam int EXTRA_LSB = 8;
	localparam int CONT_BIT  = 12;
	localparam int TRIGEN_BIT = 13;
	// command bits
	localparam int CMD_START_BIT = 0;
	localparam int CMD_ABORT_BIT = 1;
	localparam int CMD_RESET_BIT = 2;
	localparam int CMD_CLRERR_BIT = 3;
	// trigger count register
	localparam logic [7:0] TRIG_COUNT_RST = 8'h01;

	typedef enum logic [2:0] {
		continuous_mean_mode,
		burst_mean_mode,
		slot_mean_mode,
		trace_sweep_mode,
		pulse_analysis_mode,
		tail_distribution_mode,
		density_stats_mode
	} msc_mode_type;

	// measurand codes; meaning depends on mode family
	typedef enum logic [2:0] {
		feed_average,
		feed_peak,
		feed_random,
		feed_trace,
		feed_peak_trace,
		feed_random_trace,
		feed_tail_trace,
		feed_density_trace
	} msc_feed_type;

	typedef enum logic [1:0] {
		extra_none,
		extremes_report,
		random_sample_report
	} msc_extra_type;

	typedef enum logic [1:0] {
		st_idle,
		st_wait_trig,
		st_measuring
	} msc_state_type;

	localparam msc_mode_type  MODE_RST  = continuous_mean_mode;
	localparam msc_feed_type  FEED_RST  = feed_average;
	localparam msc_extra_type EXTRA_RST = extra_none;
endpackage : msc_pkg

// >>> rtl/msc_cfg_check.sv
// selector legality check: which measurand and extra value each mode accepts
module msc_cfg_check (
	input  wire logic [2:0] mode,
	input  wire logic [2:0] feed,
	input  wire logic [1:0] extra,
	output logic            feed_ok,
	output logic            extra_ok
);
	// measurand table per mode family
	always_comb begin
		feed_ok = 1'b0;
		unique case (mode)
			3'(msc_pkg::continuous_mean_mode), 3'(msc_pkg::burst_mean_mode), 3'(msc_pkg::slot_mean_mode): begin
				feed_ok = (feed == 3'(msc_pkg::feed_average)) || (feed == 3'(msc_pkg::feed_peak))
				       || (feed == 3'(msc_pkg::feed_random));
			end
			3'(msc_pkg::trace_sweep_mode): begin
				feed_ok = (feed == 3'(msc_pkg::feed_trace)) || (feed == 3'(msc_pkg::feed_peak_trace))
				       || (feed == 3'(msc_pkg::feed_random_trace));
			end
			3'(msc_pkg::pulse_analysis_mode): begin
				// pulse analysis has no own feed list; it keeps the scalar average
				feed_ok = (feed == 3'(msc_pkg::feed_average));
			end
			3'(msc_pkg::tail_distribution_mode): begin
				feed_ok = (feed == 3'(msc_pkg::feed_tail_trace));
			end
			3'(msc_pkg::density_stats_mode): begin
				feed_ok = (feed == 3'(msc_pkg::feed_density_trace));
			end
			default: begin
				feed_ok = 1'b0;
			end
		endcase
	end

	// random samples are not offered in timeslot mode; code 3 is illegal
	assign extra_ok = (extra != 2'd3)
	               && !((extra == 2'(msc_pkg::random_sample_report))
	                    && (mode == 3'(msc_pkg::slot_mean_mode)));
endmodule // msc_cfg_check

// >>> dv/msc_engine_model.sv
// behavioural measuring engine: answers each start that is not aborted with a done pulse after a set delay
module msc_engine_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       start,
	input  wire logic       abort,
	input  wire logic [7:0] delay,
	output logic            done
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] cnt;
	// count down a running measurement; an abort drops it so no stale done follows
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt  <= 8'h00;
			done <= 1'h0;
		end else begin
			done <= (cnt == 8'h01) && !abort;
			if (abort) begin
				cnt <= 8'h00;
			end else if (start) begin
				cnt <= delay;
			end else if (cnt != 8'h00) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule // msc_engine_model

// >>> dv/measurement_sequence_control_tb.sv
// self-checking bench of the measurement sequence control, driven over its apb port
module measurement_sequence_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] CF = msc_pkg::OFS_CONFIG;
	localparam logic [7:0] CM = msc_pkg::OFS_CMD;
	localparam logic [7:0] ST = msc_pkg::OFS_STATUS;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        trig = 1'h0;
	logic [7:0]  dly = 8'h14;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, slv, ms, md, ma, act, urnd, rdy, ok;
	logic [2:0]  mode_sel, feed_sel;
	logic [1:0]  extra_sel;
	int          errors = 0;
	int          cmp_count = 0;
	int          m, f;
	int          n_start = 0;
	int          n_abort = 0;
	logic [5:0]  ev;
	// clock of 4 ns period
	always #2 clk = ~clk;
	// count start and abort pulses at mid-cycle, where they have settled
	always @(negedge clk) begin
		if (ms)
			n_start++;
		if (ma)
			n_abort++;
	end
	msc_top msc_top_i (.CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TRIG_EVENT(trig), .MEAS_START(ms), .MEAS_DONE(md), .MEAS_ABORT(ma), .MEAS_ACTIVE(act),
		.MODE_SEL(mode_sel), .FEED_SEL(feed_sel), .EXTRA_SEL(extra_sel), .USE_RANDOM(urnd),
		.RESULT_READY(rdy));
	msc_engine_model msc_engine_model_i (.clk(clk), .rst_n(rst_n), .start(ms), .abort(ma), .delay(dly),
		.done(md));
	task results;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer; response and read data are taken at the edge that sees pready high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1 && k < 20);
		slv = pslverr;
		rd = prdata;
		if (pready !== 1'h1) begin
			check(0, 1);
			results();
		end
		psel <= 1'h0;
		penable <= 1'h0;
		// let a write land before callers look at the outputs
		@(posedge clk);
		#1;
	endtask
	// bounded wait for a design output to reach a level
	task automatic wait_for(ref logic s, input logic v);
		int k;
		k = 0;
		while (s !== v && k < 200) begin
			@(posedge clk);
			#1 k++;
		end
		if (s !== v) begin
			check(s, v);
			results();
		end
	endtask
	function automatic logic [31:0] cfg(input int m, input int f, input int x, input int c, input int t);
		return {18'h0, t[0], c[0], 2'h0, x[1:0], 1'h0, f[2:0], 1'h0, m[2:0]};
	endfunction
	function automatic logic fok(input int m, input int f);
		case (m)
			0, 1, 2: return f < 3;
			3: return f >= 3 && f <= 5;
			4: return f == 0;
			5: return f == 6;
			6: return f == 7;
			default: return 1'h0;
		endcase
	endfunction
	function automatic int bf(input int m);
		return m == 3 ? 3 : m == 5 ? 6 : m == 6 ? 7 : 0;
	endfunction
	// main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		apb(0, CF, 0);
		check(rd, 0);
		apb(0, ST, 0);
		check({act, rd[3:0]}, 0);
		for (m = 0; m < 8; m++) begin
			for (f = 0; f < 8; f++) begin
				apb(1, CF, cfg(m < 7 ? m : 0, bf(m), 0, 0, 0));
				apb(1, CF, cfg(m, f, 0, 0, 0));
				ev = fok(m, f) ? {m[2:0], f[2:0]} : {m < 7 ? m[2:0] : 3'h0, 3'(bf(m))};
				check({mode_sel, feed_sel}, ev);
				apb(0, ST, 0);
				check(rd[3], !fok(m, f));
				apb(1, CM, 32'h8);
			end
		end
		for (m = 0; m < 4; m++) begin
			for (f = 0; f < 4; f++) begin
				apb(1, CF, cfg(m, bf(m), 0, 0, 0));
				apb(1, CF, cfg(m, bf(m), f, 0, 0));
				ok = f < 3 && !(f == 2 && m == 2);
				check({extra_sel, urnd}, ok ? {f[1:0], f == 2} : 3'h0);
				apb(0, ST, 0);
				check(rd[3], !ok);
				apb(1, CM, 32'h8);
			end
		end
		// single run without trigger condition; selectors locked while busy
		apb(1, CF, cfg(3, 4, 1, 0, 0));
		apb(1, CM, 32'h1);
		wait_for(act, 1);
		apb(1, CF, cfg(0, 0, 0, 0, 0));
		check(mode_sel, 3);
		wait_for(rdy, 1);
		check(act, 0);
		apb(0, ST, 0);
		check(rd[2:0], 3'h4);
		check(rdy, 0);
		// three trigger events in one single run
		apb(1, msc_pkg::OFS_TRIG, 3);
		apb(1, CF, cfg(3, 4, 1, 0, 1));
		apb(1, CM, 32'h1);
		for (f = 0; f < 3; f++) begin
			repeat (4) @(posedge clk);
			apb(0, ST, 0);
			check({act, rd[1:0]}, 1);
			@(posedge clk);
			trig <= 1'h1;
			wait_for(act, 1);
			@(posedge clk);
			trig <= 1'h0;
			wait_for(md, 1);
		end
		wait_for(rdy, 1);
		apb(0, ST, 0);
		check(rd[2:0], 3'h4);
		// abort of a single run
		apb(1, msc_pkg::OFS_TRIG, 1);
		apb(1, CF, cfg(0, 0, 0, 0, 0));
		apb(1, CM, 32'h1);
		wait_for(act, 1);
		apb(1, CM, 32'h2);
		apb(0, ST, 0);
		check({act, rdy, rd[2:0]}, 0);
		check(n_abort, 1);
		check(n_start, 5);
		// continuous runs, abort inside them, then switched off
		apb(1, CF, cfg(0, 0, 0, 1, 0));
		wait_for(act, 1);
		wait_for(act, 0);
		check(rdy, 1);
		wait_for(act, 1);
		apb(1, CM, 32'h2);
		apb(0, ST, 0);
		check(rd[1:0] != 0, 1);
		check(n_abort, 2);
		wait_for(act, 1);
		apb(1, CF, cfg(3, 3, 0, 1, 0));
		check(mode_sel, 0);
		apb(1, CF, cfg(0, 0, 0, 0, 0));
		apb(0, ST, 0);
		check({act, rd[1:0]}, 0);
		// default-settings command and an unmapped address
		apb(1, CF, cfg(3, 4, 1, 0, 1));
		apb(0, CF, 0);
		check(rd, cfg(3, 4, 1, 0, 1));
		apb(1, CM, 32'h4);
		apb(0, CF, 0);
		check(rd, 0);
		apb(0, ST, 0);
		check(rd[3], 0);
		check(slv, 0);
		apb(1, 8'h10, 0);
		check(slv, 1);
		apb(0, ST, 0);
		check(rd[3], 1);
		results();
	end
endmodule // measurement_sequence_control_tb
